// >>> hw/sts_pkg.sv
// constants and carrier types of the speed status detector
package sts_pkg;

   // ***************************************************
   // scaling and ranges
   // ***************************************************
   localparam int          STS_DW        = 16;
   localparam logic [15:0] BASE_SPEED    = 16'h1000;
   localparam logic [15:0] SP_MAX        = 16'h6000;
   localparam logic [15:0] SP_MIN        = 16'hA000;
   localparam logic [15:0] MATCH_MAX     = 16'h0199;
   localparam logic [15:0] STILL_MAX     = 16'h6000;
   localparam logic [15:0] BAND_DEFAULT  = 16'h0028;

   // ***************************************************
   // reset values
   // ***************************************************
   localparam logic [15:0] SP1_RESET     = 16'h0000;
   localparam logic [15:0] SP2_RESET     = BASE_SPEED >> 3;
   localparam logic [15:0] SP3_RESET     = BASE_SPEED >> 2;
   localparam logic [15:0] SP4_RESET     = BASE_SPEED >> 1;
   localparam logic [15:0] SP5_RESET     = BASE_SPEED;
   localparam logic [15:0] STATUS_RESET  = 16'h0000;

   // ***************************************************
   // register byte offsets
   // ***************************************************
   localparam int          ADR_W         = 5;
   localparam logic [4:0]  OFS_SP1       = 5'h00;
   localparam logic [4:0]  OFS_SP2       = 5'h04;
   localparam logic [4:0]  OFS_SP3       = 5'h08;
   localparam logic [4:0]  OFS_SP4       = 5'h0C;
   localparam logic [4:0]  OFS_SP5       = 5'h10;
   localparam logic [4:0]  OFS_MATCH     = 5'h14;
   localparam logic [4:0]  OFS_STILL     = 5'h18;
   localparam logic [4:0]  OFS_STATUS    = 5'h1C;

   // ***************************************************
   // status word bit positions
   // ***************************************************
   localparam int          BIT_REFERENCE = 9;
   localparam int          BIT_STILL     = 10;
   localparam int          BIT_SP1       = 11;
   localparam int          BIT_SP3       = 13;

   // ***************************************************
   // carriers
   // ***************************************************
   typedef struct packed {
      logic              cyc;
      logic              stb;
      logic              we;
      logic [ADR_W-1:0]  adr;
      logic [3:0]        sel;
      logic [31:0]       dat;
   } sts_wb_req_t;

   typedef struct packed {
      logic [15:0] sp1;
      logic [15:0] sp2;
      logic [15:0] sp3;
      logic [15:0] sp4;
      logic [15:0] sp5;
      logic [15:0] matchBand;
      logic [15:0] stillBand;
   } sts_cfg_t;

endpackage

// >>> hw/sts_band_flag.sv
// single-threshold band speed flag without hysteresis, updated on the control tick
`timescale 1ns/1ps
module sts_band_flag (
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        updateTick,
   input  wire logic [15:0] feedback,
   input  wire logic [15:0] setpoint,
   input  wire logic [15:0] band,
   output logic             inBand
);

   logic signed [16:0] diff;
   logic        [16:0] absDiff;
   logic               next_inBand;

   // ***************************************************
   // compare
   // ***************************************************
   // 17 bits so that full-scale opposite signs cannot wrap
   always_comb begin
      diff        = 17'($signed(feedback)) - 17'($signed(setpoint));
      absDiff     = diff[16] ? 17'(-diff) : 17'(diff);
      next_inBand = inBand;
      if (updateTick) begin
         // flag holds between ticks; inside band sets, beyond band clears
         next_inBand = (absDiff <= {1'b0, band});
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         inBand <= 1'b0;
      end else begin
         inBand <= next_inBand;
      end
   end

   // ***************************************************
   // checks
   // ***************************************************
   chk_band_set : assert property (@(posedge mclk) disable iff (reset)
      updateTick && (absDiff <= {1'b0, band}) |=> inBand)
      else $error("band flag not set inside band");
   chk_band_clear : assert property (@(posedge mclk) disable iff (reset)
      updateTick && (absDiff > {1'b0, band}) |=> !inBand)
      else $error("band flag not cleared outside band");
   chk_band_hold : assert property (@(posedge mclk) disable iff (reset)
      !updateTick |=> $stable(inBand))
      else $error("band flag moved without tick");

endmodule

// >>> hw/sts_speed_status.sv
// speed status detector: setpoint registers, wishbone slave, status word
`timescale 1ns/1ps
module sts_speed_status (
   input  wire logic                 mclk,
   input  wire logic                 reset,
   input  wire sts_pkg::sts_wb_req_t wbReq,
   output logic                      wbAck,
   output logic [31:0]               wbDatOut,
   input  wire logic                 updateTick,
   input  wire logic [15:0]          velFeedback,
   input  wire logic [15:0]          speedReference,
   output logic [15:0]               statusWord
);

   sts_pkg::sts_cfg_t cfg;
   sts_pkg::sts_cfg_t next_cfg;
   logic              next_wbAck;
   logic [31:0]       next_wbDatOut;
   logic [2:0]        geStatus;
   logic [2:0]        next_geStatus;
   logic              reqValid;
   logic [3:0]        bandFlags;
   logic [2:0]        geFlags;
   logic [15:0]       bandSetpoint [4];
   logic [15:0]       bandWidth [4];
   logic [15:0]       geSetpoint [3];

   // ***************************************************
   // helpers
   // ***************************************************
   // byte lanes 0 and 1 carry the 16-bit register, upper lanes are ignored
   function automatic logic [15:0] mergeLanes(input logic [15:0] old, input logic [31:0] dat,
                                              input logic [3:0] sel);
      logic [15:0] res;
      res = old;
      if (sel[0]) begin
         res[7:0] = dat[7:0];
      end
      if (sel[1]) begin
         res[15:8] = dat[15:8];
      end
      return res;
   endfunction

   // out-of-range writes saturate rather than wrap
   function automatic logic [15:0] clampSigned(input logic [15:0] val, input logic [15:0] lo,
                                               input logic [15:0] hi);
      logic [15:0] res;
      res = val;
      if ($signed(val) < $signed(lo)) begin
         res = lo;
      end else if ($signed(val) > $signed(hi)) begin
         res = hi;
      end
      return res;
   endfunction

   // ***************************************************
   // wishbone slave and settings
   // ***************************************************
   assign reqValid = wbReq.cyc && wbReq.stb;

   always_comb begin
      next_cfg      = cfg;
      next_wbAck    = reqValid && !wbAck;
      next_wbDatOut = 32'h0000_0000;
      if (reqValid && !wbAck) begin
         unique case (wbReq.adr)
            sts_pkg::OFS_SP1:    next_wbDatOut = {16'h0000, cfg.sp1};
            sts_pkg::OFS_SP2:    next_wbDatOut = {16'h0000, cfg.sp2};
            sts_pkg::OFS_SP3:    next_wbDatOut = {16'h0000, cfg.sp3};
            sts_pkg::OFS_SP4:    next_wbDatOut = {16'h0000, cfg.sp4};
            sts_pkg::OFS_SP5:    next_wbDatOut = {16'h0000, cfg.sp5};
            sts_pkg::OFS_MATCH:  next_wbDatOut = {16'h0000, cfg.matchBand};
            sts_pkg::OFS_STILL:  next_wbDatOut = {16'h0000, cfg.stillBand};
            sts_pkg::OFS_STATUS: next_wbDatOut = {16'h0000, statusWord};
            default:             next_wbDatOut = 32'h0000_0000;
         endcase
      end
      // write lands on the edge where the master sees ack
      if (reqValid && wbAck && wbReq.we) begin
         unique case (wbReq.adr)
            sts_pkg::OFS_SP1: begin
               next_cfg.sp1 = clampSigned(mergeLanes(cfg.sp1, wbReq.dat, wbReq.sel),
                                          sts_pkg::SP_MIN, sts_pkg::SP_MAX);
            end
            sts_pkg::OFS_SP2: begin
               next_cfg.sp2 = clampSigned(mergeLanes(cfg.sp2, wbReq.dat, wbReq.sel),
                                          sts_pkg::SP_MIN, sts_pkg::SP_MAX);
            end
            sts_pkg::OFS_SP3: begin
               next_cfg.sp3 = clampSigned(mergeLanes(cfg.sp3, wbReq.dat, wbReq.sel),
                                          sts_pkg::SP_MIN, sts_pkg::SP_MAX);
            end
            sts_pkg::OFS_SP4: begin
               next_cfg.sp4 = clampSigned(mergeLanes(cfg.sp4, wbReq.dat, wbReq.sel),
                                          sts_pkg::SP_MIN, sts_pkg::SP_MAX);
            end
            sts_pkg::OFS_SP5: begin
               next_cfg.sp5 = clampSigned(mergeLanes(cfg.sp5, wbReq.dat, wbReq.sel),
                                          sts_pkg::SP_MIN, sts_pkg::SP_MAX);
            end
            sts_pkg::OFS_MATCH: begin
               next_cfg.matchBand = clampSigned(mergeLanes(cfg.matchBand, wbReq.dat, wbReq.sel),
                                                16'h0000, sts_pkg::MATCH_MAX);
            end
            sts_pkg::OFS_STILL: begin
               next_cfg.stillBand = clampSigned(mergeLanes(cfg.stillBand, wbReq.dat, wbReq.sel),
                                                16'h0000, sts_pkg::STILL_MAX);
            end
            default: begin
               next_cfg = cfg;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         cfg.sp1       <= sts_pkg::SP1_RESET;
         cfg.sp2       <= sts_pkg::SP2_RESET;
         cfg.sp3       <= sts_pkg::SP3_RESET;
         cfg.sp4       <= sts_pkg::SP4_RESET;
         cfg.sp5       <= sts_pkg::SP5_RESET;
         cfg.matchBand <= sts_pkg::BAND_DEFAULT;
         cfg.stillBand <= sts_pkg::BAND_DEFAULT;
         wbAck         <= 1'b0;
         wbDatOut      <= 32'h0000_0000;
      end else begin
         cfg      <= next_cfg;
         wbAck    <= next_wbAck;
         wbDatOut <= next_wbDatOut;
      end
   end

   // ***************************************************
   // speed flags
   // ***************************************************
   // order: reference, standstill, setpoint one, setpoint two (bits 9 to 12)
   assign bandSetpoint[0] = speedReference;
   assign bandSetpoint[1] = 16'h0000;
   assign bandSetpoint[2] = cfg.sp1;
   assign bandSetpoint[3] = cfg.sp2;
   assign bandWidth[0]    = cfg.matchBand;
   assign bandWidth[1]    = cfg.stillBand;
   assign bandWidth[2]    = cfg.matchBand;
   assign bandWidth[3]    = cfg.matchBand;
   assign geSetpoint[0]   = cfg.sp3;
   assign geSetpoint[1]   = cfg.sp4;
   assign geSetpoint[2]   = cfg.sp5;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : gBand
         sts_band_flag uBand (
            .mclk       (mclk),
            .reset      (reset),
            .updateTick (updateTick),
            .feedback   (velFeedback),
            .setpoint   (bandSetpoint[gi]),
            .band       (bandWidth[gi]),
            .inBand     (bandFlags[gi])
         );
      end
      for (gi = 0; gi < 3; gi++) begin : gGe
         // signed compare on the per-unit scale
         assign geFlags[gi] = ($signed(velFeedback) >= $signed(geSetpoint[gi]));
      end
   endgenerate

   // band flags are already registered on the tick, so only the threshold flags are caught here;
   // registering the band flags again would leave bits 9 to 12 one cycle behind bits 13 to 15
   always_comb begin
      next_geStatus = geStatus;
      if (updateTick) begin
         next_geStatus = geFlags;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         geStatus <= sts_pkg::STATUS_RESET[sts_pkg::BIT_SP3 +: 3];
      end else begin
         geStatus <= next_geStatus;
      end
   end

   // each of the seven flag bits comes straight from a flop, all move on the edge after the tick; bits 0 to 8 are zero
   assign statusWord = {geStatus, bandFlags, 9'h000};

   // ***************************************************
   // checks
   // ***************************************************
   chk_ack_single : assert property (@(posedge mclk) disable iff (reset)
      wbAck |=> !wbAck)
      else $error("ack held longer than one cycle");
   chk_ack_answer : assert property (@(posedge mclk) disable iff (reset)
      reqValid && !wbAck |=> wbAck)
      else $error("request not acknowledged next cycle");
   chk_reset_values : assert property (@(posedge mclk)
      $past(reset) |-> cfg.sp1 == 16'h0000 && cfg.sp2 == 16'h0200 && cfg.sp3 == 16'h0400
                       && cfg.sp4 == 16'h0800 && cfg.sp5 == 16'h1000)
      else $error("setpoint reset values wrong");
   chk_band_defaults : assert property (@(posedge mclk)
      $past(reset) |-> cfg.matchBand == 16'h0028 && cfg.stillBand == 16'h0028)
      else $error("band reset values wrong");
   chk_sp_range : assert property (@(posedge mclk) disable iff (reset)
      $signed(cfg.sp3) >= -16'sd24576 && $signed(cfg.sp3) <= 16'sd24576)
      else $error("setpoint out of range");
   chk_match_range : assert property (@(posedge mclk) disable iff (reset)
      cfg.matchBand <= 16'd409)
      else $error("match band out of range");
   chk_still_range : assert property (@(posedge mclk) disable iff (reset)
      !cfg.stillBand[15] && cfg.stillBand <= 16'd24576)
      else $error("standstill band out of range");
   chk_ge_flag : assert property (@(posedge mclk) disable iff (reset)
      updateTick |=> statusWord[15] == ($signed($past(velFeedback)) >= $signed($past(cfg.sp5))))
      else $error("threshold flag five wrong");
   chk_status_hold : assert property (@(posedge mclk) disable iff (reset)
      !updateTick |=> $stable(statusWord))
      else $error("status moved without tick");
   chk_status_reset : assert property (@(posedge mclk)
      reset |=> statusWord == 16'h0000)
      else $error("status not cleared by reset");

endmodule

// >>> sim/sts_drive_model.sv
// drive-side model: velocity regulator that hands out feedback, reference and the update tick
`timescale 1ns/1ps
module sts_drive_model #(
   parameter int PERIOD = 3
) (
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        run,
   input  wire logic [15:0] fbSet,
   input  wire logic [15:0] refSet,
   output logic             updateTick,
   output logic [15:0]      velFeedback,
   output logic [15:0]      speedReference
);
   int cnt;

   // feedback and reference move only with a tick, so every tick sees a settled pair
   always @(posedge mclk) begin
      if (reset) begin
         cnt <= 0;
         updateTick <= 1'b0;
         velFeedback <= 16'h0000;
         speedReference <= 16'h0000;
      end else begin
         updateTick <= run && (cnt == 0);
         if (run) begin
            cnt <= (cnt + 1) % PERIOD;
            if (cnt == 0) begin
               velFeedback <= fbSet;
               speedReference <= refSet;
            end
         end
      end
   end
endmodule

// >>> sim/testbench.sv
// self-checking bench of the speed status detector
`timescale 1ns/1ps
module testbench;
   logic                 mclk = 1'b0;
   logic                 reset = 1'b1;
   logic                 run = 1'b0;
   logic [15:0]          fbSet = 16'h0000;
   logic [15:0]          refSet = 16'h0000;
   sts_pkg::sts_wb_req_t wbReq = '0;
   logic                 wbAck;
   logic [31:0]          wbDatOut;
   logic                 updateTick;
   logic [15:0]          velFeedback;
   logic [15:0]          speedReference;
   logic [15:0]          statusWord;
   logic [15:0]          expStatus = 16'h0000;
   logic [31:0]          q;
   int                   mismatches = 0;
   int                   compares = 0;
   int                   sh[7];
   int                   DEF[7] = '{0, 4096 / 8, 4096 / 4, 4096 / 2, 4096, 4096 / 100, 4096 / 100};

   always #10 mclk = ~mclk;

   sts_speed_status sts_speed_status_i (.mclk(mclk), .reset(reset), .wbReq(wbReq), .wbAck(wbAck),
      .wbDatOut(wbDatOut), .updateTick(updateTick), .velFeedback(velFeedback),
      .speedReference(speedReference), .statusWord(statusWord));

   sts_drive_model sts_drive_model_i (.mclk(mclk), .reset(reset), .run(run), .fbSet(fbSet),
      .refSet(refSet), .updateTick(updateTick), .velFeedback(velFeedback),
      .speedReference(speedReference));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic end_sim;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   function automatic int clampv(input int v, input int lo, input int hi);
      return v < lo ? lo : (v > hi ? hi : v);
   endfunction

   function automatic int mag(input int v);
      return v < 0 ? -v : v;
   endfunction

   // one classic cycle; the wait is bounded so a dead slave ends the run
   task automatic wb(input logic [4:0] a, input logic w, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h3, dat: {16'h0000, d}};
      do begin
         @(posedge mclk);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      q = wbDatOut;
      wbReq <= '0;
      if (n >= 20) begin
         check(32'h0, 32'h1, "ack timeout");
         end_sim;
      end
   endtask

   task automatic wr(input int i, input int v);
      wb(5'(i * 4), 1'b1, 16'(v));
      sh[i] = clampv($signed(16'(v)), i < 5 ? -6 * 4096 : 0, i == 5 ? 4096 / 10 : 6 * 4096);
   endtask

   task automatic rd_all;
      for (int i = 0; i < 7; i++) begin
         wb(5'(i * 4), 1'b0, 16'h0000);
         check(q, {16'h0000, 16'(sh[i])}, "setting");
      end
      wb(5'h1C, 1'b0, 16'h0000);
      check(q, {16'h0000, expStatus}, "status read");
   endtask

   task automatic do_reset;
      reset <= 1'b1;
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      sh = DEF;
   endtask

   // feedback dwells long enough for at least two ticks
   task automatic apply(input int fb, input int rf);
      fbSet <= 16'(fb);
      refSet <= 16'(rf);
      repeat (8) @(posedge mclk);
   endtask

   // reference model: flags recomputed on each tick, held in between
   always @(posedge mclk) begin
      int fb;
      if (reset) begin
         expStatus <= 16'h0000;
      end else begin
         check({16'h0000, statusWord}, {16'h0000, expStatus}, "status word");
         if (updateTick === 1'b1) begin
            fb = $signed(velFeedback);
            expStatus <= {fb >= sh[4], fb >= sh[3], fb >= sh[2], mag(fb - sh[1]) <= sh[5],
               mag(fb - sh[0]) <= sh[5], mag(fb) <= sh[6], mag(fb - $signed(speedReference)) <= sh[5], 9'h000};
         end
      end
   end

   initial begin
      int r;
      int pts[16];
      r = $urandom(73992);
      do_reset;
      rd_all;
      wb(5'h01, 1'b0, 16'h0000);
      check(q, 32'h0, "unmapped read");
      wb(5'h05, 1'b1, 16'h1234);
      wb(5'h1C, 1'b1, 16'hFFFF);
      wr(2, 16'h7FFF);
      wr(3, 16'h8000);
      wr(5, 16'h0FFF);
      wr(6, 16'h7000);
      rd_all;
      wr(5, 16'hFFFF);
      rd_all;
      // band edges, both signs, extremes of the setpoint range
      wr(0, 1000);
      wr(1, -2000);
      wr(2, -6 * 4096);
      wr(3, 0);
      wr(4, 6 * 4096);
      wr(5, 40);
      wr(6, 40);
      pts = '{1040, 1041, 960, 959, -1960, -1959, -2040, -2041, 40, 41, -40, -41, -24577, 24575, 24576, 0};
      run <= 1'b1;
      foreach (pts[k]) apply(pts[k], pts[(k + 1) % 16]);
      for (int k = 0; k < 30; k++) begin
         run <= 1'b0;
         for (int i = 0; i < 5; i++) wr(i, $urandom_range(0, 49152) - 24576);
         wr(5, $urandom_range(0, 500));
         wr(6, $urandom_range(0, 30000));
         run <= 1'b1;
         for (int j = 0; j < 4; j++)
            apply(sh[j % 2] + $urandom_range(0, 2 * sh[5] + 2) - sh[5] - 1, $urandom_range(0, 65535));
         apply($urandom_range(0, 65535), sh[0]);
      end
      run <= 1'b0;
      rd_all;
      do_reset;
      rd_all;
      end_sim;
   end
endmodule
